/* src/nfbc_mem_if.sv */
`timescale 1ns/100ps
interface nfbc_mem_if #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input wire logic clk
);
  logic we;
  logic re;
  logic [DW/8-1:0] be;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output we, re, be, addr, wdata, input rdata);
  modport mem (input clk, we, re, be, addr, wdata, output rdata);
endinterface

/* src/nfbc_pkg.sv */
package nfbc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses (the slave decodes the low byte)
  // ----------------------------------------------------------------
  localparam logic [31:0] NFBC_CONFIG_ADDR = 32'h4E000000;
  localparam logic [31:0] NFBC_COMMAND_ADDR = 32'h4E000004;
  localparam logic [31:0] NFBC_ADDRESS_ADDR = 32'h4E000008;
  localparam logic [31:0] NFBC_DATA_ADDR = 32'h4E00000C;
  localparam logic [31:0] NFBC_STATUS_ADDR = 32'h4E000010;
  localparam logic [31:0] NFBC_PARITY_ADDR = 32'h4E000014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_SZ_BIT = 14;
  localparam int CFG_STEP_BIT = 13;
  localparam int CFG_INIT_BIT = 12;
  localparam int CFG_CE_BIT = 11;
  localparam int CFG_SETUP_LSB = 8;
  localparam int CFG_PW_LSB = 4;
  localparam int CFG_HOLD_LSB = 0;
  localparam int STA_DONE_BIT = 15;
  localparam int STA_CLE_BIT = 11;
  localparam int STA_ALE_BIT = 10;
  localparam int STA_RE_BIT = 9;
  localparam int STA_WE_BIT = 8;
  localparam int STA_MIS_BIT = 1;
  localparam int STA_RDY_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and boot constants
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_SETUP_RST = 3'h7;
  localparam logic [2:0] CFG_PW_RST = 3'h0;
  localparam logic [2:0] CFG_HOLD_RST = 3'h0;
  localparam logic [1:0] BOOT_STRAP_AUTO = 2'h0;
  localparam logic [7:0] BOOT_READ_CMD = 8'h00;
  localparam logic [12:0] BOOT_BYTES = 13'h1000;
  localparam logic [9:0] PAGE_SMALL = 10'h100;
  localparam logic [9:0] PAGE_LARGE = 10'h200;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_WAIT_NS = 100;
  localparam logic [7:0] BUSY_WAIT_CYC =
    8'((BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_CMD, K_ADR, K_WR, K_RD} nfbc_kind_t;
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} nfbc_eph_t;
  typedef enum logic [2:0] {
    B_STRAP, B_CMD, B_ADR, B_BUSY, B_WAIT, B_READ, B_DONE, B_OFF
  } nfbc_boot_t;
  typedef enum logic [2:0] {
    A_NONE, A_MEM, A_CFG, A_CMD, A_ADR, A_DAT, A_STA, A_PAR
  } nfbc_acc_t;

endpackage

/* src/nfbc_sram.sv */
`timescale 1ns/100ps
// Boot buffer: one port, byte enables, read data from a register
module nfbc_sram #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  nfbc_mem_if.mem port
);
  logic [DW-1:0] ram [0:(1<<AW)-1];
  logic [DW-1:0] rd_r;

  // Write lanes and registered read share one edge
  always_ff @(posedge port.clk) begin
    if (port.we) begin
      for (int b = 0; b < DW/8; b++) begin
        if (port.be[b]) begin
          ram[port.addr][8*b +: 8] <= port.wdata[8*b +: 8];
        end
      end
    end
    if (port.re) begin
      rd_r <= ram[port.addr];
    end
  end

  assign port.rdata = rd_r;
endmodule

/* src/nfbc_top.sv */
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// How it works
// - With auto-boot chosen, copy first 4 KB of flash into boot buffer during reset.
// - After the copy, map buffer onto bank 0 select and release processor on the same clock.
// - The auto-boot copy does no parity checking; its data must be clean.
// - Auto-boot only when both boot mode straps are sampled as 00.
// - First config strap picks 256 or 512 byte pages; reads back read-only.
// - Second config strap picks three or four address cycles; reads back.
// - Controller enable clears itself when auto-boot ends; software sets it again.
// - Writing 1 to config bit 12 restarts parity; do it per 512 bytes.
// - Config bit 11 drives chip select; inactive after auto-boot.
// - Latch setup before strobe fall is setup field plus one clock periods.
// - Strobe low width is pulse field plus one periods; resets to zero.
// - Hold after strobe rise is hold field plus one periods; resets zero.
// - Command register write puts the byte on data lines with command latch.
// - Each address register write emits one address cycle with address latch.
// - Data write programs a byte with write strobe; data read uses read strobe.
// - Status bit 0 follows ready line: 0 busy, 1 ready.
// - Status bit 15 reads 1 once auto-boot copy has completed.
// - Three parity bytes are built per 512 bytes written or read.
// - On reads, parity is compared with stored parity; software corrects.
// - Parity register packs byte two, byte one, byte zero high to low.
module nfbc_top
  import nfbc_pkg::*;
#(
  parameter int BUF_AW = 10
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bank0_chip_select,
  output logic boot_buffer_mapped,
  output logic cpu_reset_hold,
  input wire logic [1:0] boot_mode_straps,
  input wire logic [1:0] flash_config_straps,
  input wire logic [7:0] flash_data_in,
  output logic [7:0] flash_data_out,
  output logic flash_data_oe_n,
  output logic flash_cmd_latch,
  output logic flash_addr_latch,
  output logic flash_read_strobe_n,
  output logic flash_write_strobe_n,
  output logic flash_chip_select_n,
  input wire logic flash_wait_in_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    nfbc_boot_t bst;
    logic hold_cpu;
    logic mapped;
    logic done;
    logic sz512;
    logic adr4;
    logic en;
    logic ce_n;
    logic [2:0] setup;
    logic [2:0] pw;
    logic [2:0] hold;
    logic [7:0] cmd;
    logic [7:0] adr;
    logic [7:0] dat;
    nfbc_eph_t eph;
    nfbc_kind_t kind;
    logic [2:0] ecnt;
    logic [7:0] ebyte;
    logic cle;
    logic ale;
    logic re_n;
    logic we_n;
    logic doe_n;
    logic [7:0] dout;
    logic [12:0] bcnt;
    logic [9:0] pcnt;
    logic [1:0] acyc;
    logic [7:0] wcnt;
    logic [8:0] eidx;
    logic [23:0] ecc;
    logic mis;
    logic dp;
    logic dwr;
    nfbc_acc_t acc;
    logic [BUF_AW-1:0] dwa;
    logic dstep;
    logic dfin;
    logic [31:0] rdata;
  } nfbc_state_t;

  nfbc_state_t s_r;
  nfbc_state_t s_nxt;
  logic e_done;
  logic m_we;
  logic m_re;
  logic [3:0] m_be;
  logic [BUF_AW-1:0] m_addr;
  logic [31:0] m_wdata;

  nfbc_mem_if #(.AW(BUF_AW), .DW(32)) mem_bus (.clk(mclk));

  nfbc_sram #(.AW(BUF_AW), .DW(32)) u_boot_buf (
    .port(mem_bus)
  );

  assign mem_bus.we = m_we;
  assign mem_bus.re = m_re;
  assign mem_bus.be = m_be;
  assign mem_bus.addr = m_addr;
  assign mem_bus.wdata = m_wdata;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Register decode on the low address byte; the fabric decodes the base
  function automatic nfbc_acc_t acc_of(input logic [7:0] a);
    nfbc_acc_t r;
    r = A_NONE;
    if (a == NFBC_CONFIG_ADDR[7:0]) r = A_CFG;
    if (a == NFBC_COMMAND_ADDR[7:0]) r = A_CMD;
    if (a == NFBC_ADDRESS_ADDR[7:0]) r = A_ADR;
    if (a == NFBC_DATA_ADDR[7:0]) r = A_DAT;
    if (a == NFBC_STATUS_ADDR[7:0]) r = A_STA;
    if (a == NFBC_PARITY_ADDR[7:0]) r = A_PAR;
    return r;
  endfunction

  // Raw parity: [23:18] column pairs, [17:9] line set, [8:0] line prime
  function automatic logic [23:0] ecc_step(input logic [23:0] e,
                                           input logic [8:0] idx,
                                           input logic [7:0] d);
    logic [23:0] r;
    logic bp;
    r = e;
    bp = ^d;
    for (int k = 0; k < 9; k++) begin
      if (idx[k]) begin
        r[9+k] = r[9+k] ^ bp;
      end else begin
        r[k] = r[k] ^ bp;
      end
    end
    r[23] = r[23] ^ (^(d & 8'hF0));
    r[22] = r[22] ^ (^(d & 8'h0F));
    r[21] = r[21] ^ (^(d & 8'hCC));
    r[20] = r[20] ^ (^(d & 8'h33));
    r[19] = r[19] ^ (^(d & 8'hAA));
    r[18] = r[18] ^ (^(d & 8'h55));
    return r;
  endfunction

  // Reorder raw parity into the three readable bytes
  function automatic logic [23:0] ecc_pack(input logic [23:0] e);
    logic [23:0] r;
    r = 24'h000000;
    for (int k = 0; k < 8; k++) begin
      r[2*k+1] = e[9+k];
      r[2*k] = e[k];
    end
    r[23:18] = e[23:18];
    r[17] = e[17];
    r[16] = e[8];
    return r;
  endfunction

  // Launch one flash cycle; setup counter loads first
  function automatic nfbc_state_t start_op(input nfbc_state_t st,
                                           input nfbc_kind_t k,
                                           input logic [7:0] b);
    nfbc_state_t r;
    r = st;
    r.eph = E_SETUP;
    r.kind = k;
    r.ecnt = st.setup;
    r.ebyte = b;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    e_done = 1'b0;
    m_we = 1'b0;
    m_re = 1'b0;
    m_be = 4'h0;
    m_addr = s_r.dwa;
    m_wdata = 32'h00000000;

    // Cycle engine: setup, strobe pulse, hold
    case (s_r.eph)
      E_SETUP: begin
        if (s_r.ecnt == 3'h0) begin
          s_nxt.eph = E_PULSE;
          s_nxt.ecnt = s_r.pw;
        end else begin
          s_nxt.ecnt = s_r.ecnt - 3'h1;
        end
      end
      E_PULSE: begin
        // Sampling every pulse cycle keeps the last value before release
        if (s_r.kind == K_RD) begin
          s_nxt.ebyte = flash_data_in;
        end
        if (s_r.ecnt == 3'h0) begin
          s_nxt.eph = E_HOLD;
          s_nxt.ecnt = s_r.hold;
        end else begin
          s_nxt.ecnt = s_r.ecnt - 3'h1;
        end
      end
      E_HOLD: begin
        if (s_r.ecnt == 3'h0) begin
          s_nxt.eph = E_IDLE;
          e_done = 1'b1;
        end else begin
          s_nxt.ecnt = s_r.ecnt - 3'h1;
        end
      end
      default: ;
    endcase

    // Parity runs on software data bytes only, never on the boot copy
    if (e_done && !s_r.hold_cpu && (s_r.kind == K_WR || s_r.kind == K_RD)) begin
      s_nxt.ecc = ecc_step(s_r.ecc, s_r.eidx, s_r.ebyte);
      s_nxt.eidx = s_r.eidx + 9'h1;
    end

    // Auto-boot sequencer, runs while the processor is held
    case (s_r.bst)
      B_STRAP: begin
        s_nxt.sz512 = flash_config_straps[0];
        s_nxt.adr4 = flash_config_straps[1];
        if (boot_mode_straps == BOOT_STRAP_AUTO) begin
          s_nxt.bst = B_CMD;
          s_nxt.ce_n = 1'b0;
        end else begin
          s_nxt.bst = B_OFF;
          s_nxt.hold_cpu = 1'b0;
        end
      end
      B_CMD: begin
        if (s_r.eph == E_IDLE) begin
          s_nxt = start_op(s_nxt, K_CMD, BOOT_READ_CMD);
          s_nxt.bst = B_ADR;
          s_nxt.acyc = 2'h0;
          s_nxt.pcnt = s_r.sz512 ? PAGE_LARGE : PAGE_SMALL;
        end
      end
      B_ADR: begin
        if (s_r.eph == E_IDLE) begin
          // Column byte zero, then page number, upper bytes zero
          if (s_r.acyc == 2'h1) begin
            s_nxt = start_op(s_nxt, K_ADR, s_r.sz512 ? {5'h00, s_r.bcnt[11:9]} :
                                                     {4'h0, s_r.bcnt[11:8]});
          end else begin
            s_nxt = start_op(s_nxt, K_ADR, 8'h00);
          end
          if (s_r.acyc == (s_r.adr4 ? 2'h3 : 2'h2)) begin
            s_nxt.bst = B_BUSY;
            s_nxt.wcnt = BUSY_WAIT_CYC;
          end else begin
            s_nxt.acyc = s_r.acyc + 2'h1;
          end
        end
      end
      B_BUSY: begin
        // Give the flash time to pull its ready line low first
        if (s_r.eph == E_IDLE) begin
          if (s_r.wcnt == 8'h00) begin
            s_nxt.bst = B_WAIT;
          end else begin
            s_nxt.wcnt = s_r.wcnt - 8'h01;
          end
        end
      end
      B_WAIT: begin
        if (flash_wait_in_n) begin
          s_nxt.bst = B_READ;
        end
      end
      B_READ: begin
        if (e_done) begin
          m_we = 1'b1;
          m_addr = s_r.bcnt[BUF_AW+1:2];
          m_be = 4'h1 << s_r.bcnt[1:0];
          m_wdata = {4{s_r.ebyte}};
          s_nxt.bcnt = s_r.bcnt + 13'h0001;
        end else if (s_r.eph == E_IDLE) begin
          if (s_r.pcnt == 10'h000) begin
            s_nxt.bst = (s_r.bcnt == BOOT_BYTES) ? B_DONE : B_CMD;
          end else begin
            s_nxt = start_op(s_nxt, K_RD, 8'h00);
            s_nxt.pcnt = s_r.pcnt - 10'h001;
          end
        end
      end
      B_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.mapped = 1'b1;
        s_nxt.hold_cpu = 1'b0;
        s_nxt.en = 1'b0;
        s_nxt.ce_n = 1'b1;
        s_nxt.bst = B_OFF;
      end
      default: ;
    endcase

    // ----------------------------------------------------------------
    // Bus data phase
    // ----------------------------------------------------------------
    if (s_r.dp && !s_r.dfin) begin
      case (s_r.acc)
        A_MEM: begin
          // Reads take a stall: the port returns read data one clock after the request
          if (s_r.dwr) begin
            m_we = 1'b1;
            m_be = 4'hF;
            m_wdata = hwdata;
            s_nxt.dfin = 1'b1;
          end else if (!s_r.dstep) begin
            m_re = 1'b1;
            s_nxt.dstep = 1'b1;
          end else begin
            s_nxt.rdata = mem_bus.rdata;
            s_nxt.dfin = 1'b1;
          end
        end
        A_CMD, A_ADR, A_DAT: begin
          if (!s_r.dstep) begin
            if (s_r.dwr) begin
              if (s_r.acc == A_CMD) s_nxt.cmd = hwdata[7:0];
              if (s_r.acc == A_ADR) s_nxt.adr = hwdata[7:0];
              if (s_r.acc == A_DAT) s_nxt.dat = hwdata[7:0];
            end
            // Disabled controller or plain readback: answer at once
            if (!s_r.en || s_r.hold_cpu || (!s_r.dwr && s_r.acc != A_DAT)) begin
              s_nxt.rdata = {24'h000000, (s_r.acc == A_CMD) ? s_r.cmd :
                             (s_r.acc == A_ADR) ? s_r.adr : s_r.dat};
              s_nxt.dfin = 1'b1;
            end else if (s_r.eph == E_IDLE) begin
              if (s_r.acc == A_CMD) begin
                s_nxt = start_op(s_nxt, K_CMD, hwdata[7:0]);
              end else if (s_r.acc == A_ADR) begin
                s_nxt = start_op(s_nxt, K_ADR, hwdata[7:0]);
              end else begin
                s_nxt = start_op(s_nxt, s_r.dwr ? K_WR : K_RD, hwdata[7:0]);
              end
              s_nxt.dstep = 1'b1;
            end
          end else if (s_r.eph == E_IDLE) begin
            // Bus stalls until the flash cycle ends
            s_nxt.dfin = 1'b1;
            if (!s_r.dwr) begin
              s_nxt.dat = s_r.ebyte;
              s_nxt.rdata = {24'h000000, s_r.ebyte};
            end
          end
        end
        A_CFG: begin
          if (s_r.dwr) begin
            s_nxt.en = hwdata[CFG_EN_BIT];
            s_nxt.ce_n = hwdata[CFG_CE_BIT];
            s_nxt.setup = hwdata[CFG_SETUP_LSB +: 3];
            s_nxt.pw = hwdata[CFG_PW_LSB +: 3];
            s_nxt.hold = hwdata[CFG_HOLD_LSB +: 3];
            if (hwdata[CFG_INIT_BIT]) begin
              s_nxt.ecc = 24'h000000;
              s_nxt.eidx = 9'h000;
              s_nxt.mis = 1'b0;
            end
          end
          s_nxt.rdata = 32'h00000000;
          s_nxt.rdata[CFG_EN_BIT] = s_r.en;
          s_nxt.rdata[CFG_SZ_BIT] = s_r.sz512;
          s_nxt.rdata[CFG_STEP_BIT] = s_r.adr4;
          s_nxt.rdata[CFG_CE_BIT] = s_r.ce_n;
          s_nxt.rdata[CFG_SETUP_LSB +: 3] = s_r.setup;
          s_nxt.rdata[CFG_PW_LSB +: 3] = s_r.pw;
          s_nxt.rdata[CFG_HOLD_LSB +: 3] = s_r.hold;
          s_nxt.dfin = 1'b1;
        end
        A_STA: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rdata[STA_DONE_BIT] = s_r.done;
          s_nxt.rdata[STA_CLE_BIT] = s_r.cle;
          s_nxt.rdata[STA_ALE_BIT] = s_r.ale;
          s_nxt.rdata[STA_RE_BIT] = s_r.re_n;
          s_nxt.rdata[STA_WE_BIT] = s_r.we_n;
          s_nxt.rdata[STA_MIS_BIT] = s_r.mis;
          s_nxt.rdata[STA_RDY_BIT] = flash_wait_in_n;
          s_nxt.dfin = 1'b1;
        end
        A_PAR: begin
          // Writing the stored parity compares it with the running one
          if (s_r.dwr) begin
            s_nxt.mis = (hwdata[23:0] != ecc_pack(s_r.ecc));
          end
          s_nxt.rdata = {8'h00, ecc_pack(s_r.ecc)};
          s_nxt.dfin = 1'b1;
        end
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.dfin = 1'b1;
        end
      endcase
    end

    // Address phase, taken whenever the bus is ready
    if (hready) begin
      s_nxt.dfin = 1'b0;
      s_nxt.dstep = 1'b0;
      s_nxt.dp = 1'b0;
      s_nxt.acc = A_NONE;
      if (htrans[1] && bank0_chip_select && s_r.mapped) begin
        s_nxt.dp = 1'b1;
        s_nxt.acc = A_MEM;
      end else if (htrans[1] && hsel) begin
        s_nxt.dp = 1'b1;
        s_nxt.acc = acc_of(haddr[7:0]);
      end
      s_nxt.dwr = hwrite;
      s_nxt.dwa = haddr[BUF_AW+1:2];
    end

    // Pins follow the next phase so they come straight from flops
    s_nxt.cle = (s_nxt.eph != E_IDLE) && (s_nxt.kind == K_CMD);
    s_nxt.ale = (s_nxt.eph != E_IDLE) && (s_nxt.kind == K_ADR);
    s_nxt.we_n = !((s_nxt.eph == E_PULSE) && (s_nxt.kind != K_RD));
    s_nxt.re_n = !((s_nxt.eph == E_PULSE) && (s_nxt.kind == K_RD));
    s_nxt.doe_n = !((s_nxt.eph != E_IDLE) && (s_nxt.kind != K_RD));
    s_nxt.dout = s_nxt.doe_n ? 8'h00 : s_nxt.ebyte;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.hold_cpu <= 1'b1;
      s_r.ce_n <= 1'b1;
      s_r.setup <= CFG_SETUP_RST;
      s_r.pw <= CFG_PW_RST;
      s_r.hold <= CFG_HOLD_RST;
      s_r.re_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.doe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = s_r.rdata;
  assign hreadyout = !s_r.dp || s_r.dfin;
  assign hresp = 1'b0;
  assign boot_buffer_mapped = s_r.mapped;
  assign cpu_reset_hold = s_r.hold_cpu;
  assign flash_data_out = s_r.dout;
  assign flash_data_oe_n = s_r.doe_n;
  assign flash_cmd_latch = s_r.cle;
  assign flash_addr_latch = s_r.ale;
  assign flash_read_strobe_n = s_r.re_n;
  assign flash_write_strobe_n = s_r.we_n;
  assign flash_chip_select_n = s_r.ce_n;

endmodule

/* tb/nfbc_bench.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin got_v = 32'(g); exp_v = 32'(e); n_compared++; \
  if (got_v !== exp_v) begin err_total++; \
  $display("unexpected at %0t got %h expected %h", $time, got_v, exp_v); end end
module nfbc_bench;
  import nfbc_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, bank_sel = 1'b0;
  logic [1:0] htrans = 2'h0, straps = 2'h0, cfg_straps = 2'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, got_v, exp_v;
  logic [7:0] f_in, f_out, exp_q[$];
  logic hreadyout, hresp, mapped, hold, oe_n, cle, ale, re_n, we_n, ce_n, wait_n;
  int err_total = 0, n_compared = 0;
  int wl[4] = '{0, 127, 128, 1023};
  int ra[3] = '{0, 2, 0};
  // ------------------------------
  // Clock and the two parties
  // ------------------------------
  always #25 mclk = ~mclk;
  nfbc_top uut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bank0_chip_select(bank_sel),
    .boot_buffer_mapped(mapped), .cpu_reset_hold(hold), .boot_mode_straps(straps),
    .flash_config_straps(cfg_straps), .flash_data_in(f_in), .flash_data_out(f_out),
    .flash_data_oe_n(oe_n), .flash_cmd_latch(cle), .flash_addr_latch(ale),
    .flash_read_strobe_n(re_n), .flash_write_strobe_n(we_n),
    .flash_chip_select_n(ce_n), .flash_wait_in_n(wait_n));
  nfbc_flash_model fm (.dq_in(f_out), .cle(cle), .ale(ale), .re_n(re_n), .we_n(we_n),
    .ce_n(ce_n), .dq_out(f_in), .rdy(wait_n));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Byte n of flash as the stand-in serves it, 512-byte pages
  function automatic logic [7:0] pat(input int n);
    return 8'((n % 512) * 7 + (n / 512) * 13);
  endfunction
  // Inputs sampled at the edge are the settled values before it
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= a[30];
    bank_sel <= !a[30];
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 5000);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 5000);
    r = hrdata;
    if (n >= 5000) err_total++;
  endtask
  // Boot copy, program, read, parity, then a second boot choice
  initial begin
    logic [31:0] r, s;
    s = 32'hB89E;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 60000 && hold !== 1'b0; i++) @(posedge mclk);
    `CHK({hold, mapped}, 2'h1)
    fm.c_q.delete();
    fm.a_q.delete();
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r, 32'h8301)
    ahb(0, NFBC_CONFIG_ADDR, 0, r);
    `CHK(r, 32'h4F00)
    ahb(0, NFBC_PARITY_ADDR, 0, r);
    `CHK(r, 0)
    foreach (wl[k]) begin
      ahb(0, 32'(wl[k] * 4), 0, r);
      `CHK(r, {pat(wl[k]*4+3), pat(wl[k]*4+2), pat(wl[k]*4+1), pat(wl[k]*4)})
    end
    ahb(1, NFBC_CONFIG_ADDR, 32'h9121, r);
    ahb(0, NFBC_CONFIG_ADDR, 0, r);
    `CHK(r, 32'hC121)
    ahb(1, NFBC_COMMAND_ADDR, 32'h80, r);
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      exp_q.push_back(s[7:0]);
      ahb(1, i < 3 ? NFBC_ADDRESS_ADDR : NFBC_DATA_ADDR, s, r);
    end
    `CHK(fm.c_q.pop_front(), 8'h80)
    for (int i = 0; i < 6; i++) begin
      `CHK(i < 3 ? fm.a_q.pop_front() : fm.w_q.pop_front(), exp_q.pop_front())
    end
    ahb(1, NFBC_COMMAND_ADDR, 32'h00, r);
    foreach (ra[k]) ahb(1, NFBC_ADDRESS_ADDR, ra[k], r);
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r[0], 1'b0)
    repeat (10) @(posedge mclk);
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r[0], 1'b1)
    for (int i = 0; i < 3; i++) begin
      ahb(0, NFBC_DATA_ADDR, 0, r);
      `CHK(r, pat(1024 + i))
    end
    ahb(1, NFBC_CONFIG_ADDR, 32'h9121, r);
    ahb(0, NFBC_PARITY_ADDR, 0, r);
    `CHK(r, 0)
    ahb(0, NFBC_DATA_ADDR, 0, r);
    `CHK(r, pat(1027))
    ahb(0, NFBC_PARITY_ADDR, 0, r);
    `CHK(r, 32'h995555)
    ahb(1, NFBC_PARITY_ADDR, 32'h995555, r);
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r[1], 1'b0)
    ahb(1, NFBC_PARITY_ADDR, 32'h123456, r);
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r[1], 1'b1)
    ahb(1, NFBC_CONFIG_ADDR, 32'h9121, r);
    ahb(0, NFBC_STATUS_ADDR, 0, r);
    `CHK(r[1], 1'b0)
    ahb(0, 32'h4E000018, 0, r);
    `CHK(r | hresp, 0)
    straps <= 2'h2;
    cfg_straps <= 2'h2;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK({hold, mapped, ce_n}, 3'h1)
    ahb(0, NFBC_CONFIG_ADDR, 0, r);
    `CHK(r, 32'h2F00)
    results();
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Boot copy is the long part; allow under twice its span
  initial begin
    #4000000;
    err_total++;
    results();
  end
endmodule
bind nfbc_top nfbc_properties chk (.mclk(mclk), .reset(reset),
  .boot_buffer_mapped(boot_buffer_mapped), .cpu_reset_hold(cpu_reset_hold),
  .boot_mode_straps(boot_mode_straps), .flash_data_out(flash_data_out),
  .flash_data_oe_n(flash_data_oe_n), .flash_cmd_latch(flash_cmd_latch),
  .flash_addr_latch(flash_addr_latch), .flash_read_strobe_n(flash_read_strobe_n),
  .flash_write_strobe_n(flash_write_strobe_n), .flash_chip_select_n(flash_chip_select_n));

/* tb/nfbc_flash_model.sv */
`timescale 1ns/100ps
// ------------------------------
// Flash stand-in
// ------------------------------
module nfbc_flash_model (
  input logic [7:0] dq_in,
  input logic cle,
  input logic ale,
  input logic re_n,
  input logic we_n,
  input logic ce_n,
  output logic [7:0] dq_out,
  output logic rdy
);
  logic [7:0] c_q[$], a_q[$], w_q[$];
  logic [7:0] last = 8'hA5;
  int nadr, page, col;
  initial dq_out = 8'h5A;
  initial rdy = 1'b1;
  // Bytes are taken as the strobe rises, while still driven
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      c_q.push_back(dq_in);
      nadr = 0;
      col = 0;
    end else if (!ce_n && ale) begin
      a_q.push_back(dq_in);
      page = (nadr == 1) ? int'(dq_in) : page;
      nadr++;
    end else if (!ce_n) begin
      w_q.push_back(dq_in);
    end
  end
  // Released bus shows the inverse, never a stale byte
  always @(negedge re_n) begin
    last = 8'(col * 7 + page * 13);
    dq_out = last;
    col++;
  end
  always @(posedge re_n) dq_out = ~last;
  // Busy for 400 ns after an address byte; a fall of ale during the wait is missed
  always @(negedge ale) begin
    rdy = 1'b0;
    #400;
    rdy = 1'b1;
  end
endmodule

/* tb/nfbc_properties.sv */
`timescale 1ns/100ps
// ------------------------------
// Flash pin and boot buffer mapping checks
// ------------------------------
module nfbc_properties (
  input logic mclk,
  input logic reset,
  input logic boot_buffer_mapped,
  input logic cpu_reset_hold,
  input logic [1:0] boot_mode_straps,
  input logic [7:0] flash_data_out,
  input logic flash_data_oe_n,
  input logic flash_cmd_latch,
  input logic flash_addr_latch,
  input logic flash_read_strobe_n,
  input logic flash_write_strobe_n,
  input logic flash_chip_select_n
);
  // Short names keep each property on one line
  wire we_n = flash_write_strobe_n;
  wire re_n = flash_read_strobe_n;
  wire oe_n = flash_data_oe_n;
  wire cle = flash_cmd_latch;
  wire ale = flash_addr_latch;
  wire boot = boot_mode_straps == 2'h0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_MAP: assert property (boot && !cpu_reset_hold |-> boot_buffer_mapped)
    else $error("buffer not mapped at release");
  AST_NOMAP: assert property (!boot |-> !boot_buffer_mapped)
    else $error("buffer mapped without auto-boot");
  AST_CE_OFF: assert property ($fell(cpu_reset_hold) |-> flash_chip_select_n)
    else $error("chip select active at release");
  AST_WE_DRIVE: assert property (!we_n |-> !oe_n && re_n)
    else $error("write strobe without driven data");
  AST_RD_FLOAT: assert property (!re_n |-> oe_n && !cle && !ale)
    else $error("read strobe while driving");
  AST_LATCH: assert property (cle || ale |-> !oe_n && !(cle && ale))
    else $error("bad latch state");
  AST_WIDTH: assert property ($fell(we_n) |-> ##[1:8] we_n)
    else $error("write strobe too long");
  AST_HOLD: assert property ($rose(we_n) |-> !oe_n && $stable(flash_data_out))
    else $error("data dropped at strobe release");
endmodule
